// ===== hw/dhsc_pkg.sv
// Purpose: Shared constants and types for the host status/check block
// Assumes: Register select values are the printed register addresses
// Notes:   Serial codes are the eight address bits with B0 in bit 0
package dhsc_pkg;
    // Register select values on the parallel bus
    localparam logic [3:0]  DHSC_SEL_PKT    = 4'h0;
    localparam logic [3:0]  DHSC_SEL_STATUS = 4'h1;
    localparam logic [3:0]  DHSC_SEL_INDEX  = 4'h2;
    localparam logic [3:0]  DHSC_SEL_CTL1   = 4'h4;
    localparam logic [3:0]  DHSC_SEL_CHECK  = 4'h6;
    // Control register 1 field positions
    localparam int          DHSC_CTL1_CLR   = 7;
    localparam int          DHSC_CTL1_HALT  = 2;
    // Serial address codes, first bit shifted in bit 0
    localparam logic [7:0]  DHSC_SER_CTL    = 8'hFA;
    localparam logic [7:0]  DHSC_SER_PKT    = 8'hFB;
    localparam logic [7:0]  DHSC_SER_CRC    = 8'hFC;
    localparam logic [7:0]  DHSC_SER_REG    = 8'hFD;
    // Check polynomial x^16 + x^12 + x^5 + 1 and cleared value
    localparam logic [15:0] DHSC_CRC_POLY   = 16'h1021;
    localparam logic [15:0] DHSC_CRC_CLEAR  = 16'h0000;
    // Packet geometry: 22 data bytes, 17 words of 272 bits
    localparam logic [4:0]  DHSC_PKT_BYTES  = 5'h16;
    localparam int          DHSC_PKT_WORDS  = 17;
    localparam logic [8:0]  DHSC_SER_HDR    = 9'h010;
    localparam logic [8:0]  DHSC_SER_BITS   = 9'h120;
    localparam logic [8:0]  DHSC_CTL_BITS   = 9'h00F;
    localparam logic [2:0]  DHSC_BYTE_LAST  = 3'h7;

    // Per-packet facts from the decoder core
    typedef struct packed {
        logic       second_pass;  // Vertical and second pass done
        logic       block_locked; // Block sync held
        logic       frame_locked; // Frame sync held
        logic       err;          // Uncorrected or CRC failure
        logic       parity;       // Inferred parity block
        logic       head;         // Inferred frame head
        logic [7:0] block_num;    // Data or parity block number
    } dhsc_info_t;

    // Serial transfer function latched at chip enable rise
    typedef enum logic [2:0] {
        DHSC_M_NONE, DHSC_M_CTL, DHSC_M_PKT, DHSC_M_CRC, DHSC_M_REG
    } dhsc_mode_t;

    // Main-domain state
    typedef struct packed {
        logic [3:0]  s1_sel, s2_sel;   // Select line synchroniser
        logic [2:0]  s1_ctl, s2_ctl;   // cs, rd, wr active high
        logic        rd_q, wr_q;       // Previous synced strobes
        logic        s1_wm, s2_wm;     // Word mode synchroniser
        logic [15:0] s1_din, s2_din;   // Data bus synchroniser
        logic [7:0]  status;           // Packet status
        logic [7:0]  index;            // Block index
        logic [15:0] crc;              // Division register
        logic        crc_ok;           // All-zero indication
        logic        clr;              // Check clear control
        logic        halt;             // Vertical pass halt
        logic [4:0]  ptr;              // Next packet byte
        logic        have;             // Packet bytes remain
        logic [15:0] dout;             // Read data
        logic        doe;              // Read data drive
        logic        upd;              // Registers just updated
        logic        irq;              // Packet interrupt
        logic        ctl_stb;          // Control write out
        logic [3:0]  ctl_addr;
        logic [7:0]  ctl_data;
        logic        pt1, pt2, pt3;    // Link post toggle sync
        logic        snap_tgl;         // New snapshot event
    } dhsc_main_t;

    // Link-domain state
    typedef struct packed {
        logic        ce_q;             // Chip enable last edge
        logic [7:0]  addr;             // Address shifter
        dhsc_mode_t  mode;             // Latched function
        logic [8:0]  cnt;              // Bits since enable rise or the last posted word
        logic [15:0] sh;               // Input shifter
        logic [15:0] post_word;        // Word handed to main
        logic        post_crc;         // Word is a check byte
        logic        post_tgl;         // Hand-over event
        logic        st1, st2, st3;    // Snapshot toggle sync
        logic [15:0] snap;             // Index and status copy
        logic        ok1, ok2;         // Check-ok level sync
        logic        do_out;           // Serial out level
        logic        do_oe;            // Pulls serial out low
    } dhsc_link_t;
endpackage

// ===== hw/dhsc_top.sv
// Purpose: Host status, block index, group check and host buses
// Assumes: Core inputs on clk_sys; serial pins timed to the shift clock
// Notes:   Packet words are written by the core before done
//
// Contract
// - Status bit 7 marks second pass packets
// - Bits 6,5 give block and frame lock
// - Bit 4 flags failed correction or CRC
// - Bit 3 marks inferred parity block
// - Bit 2 marks frame head, first pass
// - Bit 1 is check-zero at read time
// - Index register gives block number
// - Second pass output carries no parity packets
// - Index undefined while vertical pass halted
// - Registers update just before the interrupt
// - Check data divided by x^16+x^12+x^5+1
// - Check-ok pin high when register zero; code holds it low in reset and until the first clock after release
// - Groups unlimited, serial groups may split
// - Check register writable only in parallel; code also feeds it serial check bytes (code FC)
// - Parallel packet is exactly 176 bits
// - Parallel packet read in 8/16-bit units
// - Address shifted, function latched at enable
// - Four serial address codes decoded
// - Serial control write carries 16 bits
// - Serial packet is up to 288 bits
// - Clear bit holds check register cleared
`timescale 1ns/1ns
module dhsc_top
    import dhsc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        serial_shift_clock,
    input  wire logic        serial_chip_enable,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_oe,
    input  wire logic [3:0]  reg_select_lines,
    input  wire logic        chip_select_n,
    input  wire logic        read_n,
    input  wire logic        write_n,
    input  wire logic        word_mode,
    input  wire logic [15:0] bus_data_in,
    output logic [15:0]      bus_data_out,
    output logic             bus_data_oe,
    input  wire dhsc_info_t  core_info,
    input  wire logic        core_done,
    input  wire logic        core_load_en,
    input  wire logic [4:0]  core_load_addr,
    input  wire logic [15:0] core_load_word,
    output logic             packet_irq,
    output logic             xfer_request,
    output logic             group_check_ok,
    output logic             ctl_wr_stb,
    output logic [3:0]       ctl_wr_addr,
    output logic [7:0]       ctl_wr_data
);

    ////////////////////////////////////////////////////////////////
    // Storage and state
    dhsc_main_t  st, next_st;            // Main domain
    dhsc_link_t  lk, next_lk;            // Link domain
    logic [15:0] pkt_mem [DHSC_PKT_WORDS]; // 272 packet bits

    // One byte-wide division step, first bit is bit 7
    function automatic logic [15:0] crc_byte(
        input logic [15:0] c,
        input logic [7:0]  b
    );
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ b[i]) begin
                r = {r[14:0], 1'b0} ^ DHSC_CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Packet byte k of the 22 data bytes, high half first
    function automatic logic [7:0] pkt_byte(input logic [4:0] k);
        logic [15:0] w;
        w = pkt_mem[k[4:1]];
        return k[0] ? w[7:0] : w[15:8];
    endfunction

    ////////////////////////////////////////////////////////////////
    // Packet store written by the core
    always_ff @(posedge clk_sys) begin
        if (core_load_en && (32'(core_load_addr) < DHSC_PKT_WORDS)) begin
            pkt_mem[core_load_addr] <= core_load_word;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Main domain next state
    always_comb begin
        logic        rd_go;    // Read strobe start
        logic        wr_go;    // Write strobe start
        logic        ck_go;    // A check byte arrives
        logic [7:0]  ck_byte;
        logic        lk_go;    // Link word arrived
        logic        pk_go;    // Packet accepted
        pk_go   = core_done && !(core_info.second_pass && core_info.parity);
        rd_go   = 1'b0;
        wr_go   = 1'b0;
        ck_go   = 1'b0;
        ck_byte = 8'h00;
        lk_go   = 1'b0;
        next_st = st;
        // Two-flop pin synchronisers
        next_st.s1_sel = reg_select_lines;
        next_st.s2_sel = st.s1_sel;
        next_st.s1_ctl = {~chip_select_n, ~read_n, ~write_n};
        next_st.s2_ctl = st.s1_ctl;
        next_st.s1_wm  = word_mode;
        next_st.s2_wm  = st.s1_wm;
        next_st.s1_din = bus_data_in;
        next_st.s2_din = st.s1_din;
        next_st.rd_q   = st.s2_ctl[1];
        next_st.wr_q   = st.s2_ctl[0];
        // Toggle sync from the link; data word is already stable
        next_st.pt1    = lk.post_tgl;
        next_st.pt2    = st.pt1;
        next_st.pt3    = st.pt2;
        lk_go = st.pt2 ^ st.pt3;
        rd_go = st.s2_ctl[2] && st.s2_ctl[1] && !st.rd_q;
        wr_go = st.s2_ctl[2] && st.s2_ctl[0] && !st.wr_q;
        next_st.doe     = st.s2_ctl[2] && st.s2_ctl[1];
        next_st.ctl_stb = 1'b0;
        next_st.upd     = 1'b0;
        // Interrupt one cycle after the registers settle
        next_st.irq     = st.upd;

        // Packet arrival; second pass parity is dropped
        if (pk_go) begin
            next_st.status = {core_info.second_pass,
                              core_info.block_locked,
                              core_info.frame_locked,
                              core_info.err,
                              core_info.parity,
                              core_info.head,
                              2'b00};
            next_st.index    = core_info.block_num;
            next_st.upd      = 1'b1;
            next_st.snap_tgl = ~st.snap_tgl;
        end

        // Parallel reads; selects at zero give packet data
        if (rd_go) begin
            unique case (st.s2_sel)
                DHSC_SEL_STATUS: begin
                    // Check flag taken live as the read starts
                    next_st.dout = {8'h00, st.status[7:2], st.crc_ok, 1'b0};
                end
                DHSC_SEL_INDEX: begin
                    // Halted vertical pass: index reads as zero
                    next_st.dout = st.halt ? 16'h0000 : {8'h00, st.index};
                end
                DHSC_SEL_PKT: begin
                    if (!st.have) begin
                        next_st.dout = 16'h0000;
                    end else if (st.s2_wm && (st.ptr < DHSC_PKT_BYTES - 5'h01)) begin
                        next_st.dout = {pkt_byte(st.ptr), pkt_byte(st.ptr + 5'h01)};
                        next_st.ptr  = st.ptr + 5'h02;
                    end else begin
                        next_st.dout = {8'h00, pkt_byte(st.ptr)};
                        next_st.ptr  = st.ptr + 5'h01;
                    end
                    // Stops at 176 bits, later reads give zero
                    next_st.have = st.have && (next_st.ptr < DHSC_PKT_BYTES);
                end
                default: begin
                    next_st.dout = 16'h0000;
                end
            endcase
        end
        // Arrival wins over a packet read in the same cycle
        if (pk_go) begin
            next_st.ptr  = 5'h00;
            next_st.have = 1'b1;
        end

        // Parallel writes: check bytes here, the rest go out
        if (wr_go) begin
            if (st.s2_sel == DHSC_SEL_CHECK) begin
                ck_go   = 1'b1;
                ck_byte = st.s2_din[7:0];
            end else begin
                next_st.ctl_stb  = 1'b1;
                next_st.ctl_addr = st.s2_sel;
                next_st.ctl_data = st.s2_din[7:0];
            end
        end else if (lk_go) begin
            // Link words lose to a parallel write in one cycle
            if (lk.post_crc) begin
                ck_go   = 1'b1;
                ck_byte = lk.post_word[15:8];
            end else begin
                next_st.ctl_stb  = 1'b1;
                next_st.ctl_addr = lk.post_word[11:8];
                next_st.ctl_data = lk.post_word[7:0];
            end
        end
        // Control register 1 bits that steer this block
        if (next_st.ctl_stb && (next_st.ctl_addr == DHSC_SEL_CTL1)) begin
            next_st.clr  = next_st.ctl_data[DHSC_CTL1_CLR];
            next_st.halt = next_st.ctl_data[DHSC_CTL1_HALT];
        end

        // Division register; clear level overrides data
        if (st.clr) begin
            next_st.crc = DHSC_CRC_CLEAR;
        end else if (ck_go) begin
            next_st.crc = crc_byte(st.crc, ck_byte);
        end
        next_st.crc_ok = (next_st.crc == DHSC_CRC_CLEAR);
    end

    // Main domain register; reset zeroes all read state
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Link domain next state
    always_comb begin
        dhsc_mode_t  m;        // Function for this edge
        logic [15:0] hdr;      // Status then index, bit 0 first
        logic [8:0]  pos;      // Bit position in the packet body
        logic        bit_v;
        m       = lk.mode;
        hdr     = 16'h0000;
        pos     = 9'h000;
        bit_v   = 1'b1;
        next_lk = lk;
        next_lk.ce_q = serial_chip_enable;
        // Snapshot toggle sync; copy only when it settles
        next_lk.st1 = st.snap_tgl;
        next_lk.st2 = lk.st1;
        next_lk.st3 = lk.st2;
        if (lk.st2 ^ lk.st3) begin
            next_lk.snap = {st.index, st.status};
        end
        next_lk.ok1 = st.crc_ok;
        next_lk.ok2 = lk.ok1;

        if (!serial_chip_enable) begin
            // Address bits shift while enable is low
            next_lk.addr   = {serial_data_in, lk.addr[7:1]};
            next_lk.cnt    = 9'h000;
            next_lk.mode   = DHSC_M_NONE;
            next_lk.do_out = 1'b1;
            next_lk.do_oe  = 1'b0;
        end else begin
            // First edge after the rise latches the function
            if (!lk.ce_q) begin
                unique case (lk.addr)
                    DHSC_SER_CTL: m = DHSC_M_CTL;
                    DHSC_SER_PKT: m = DHSC_M_PKT;
                    DHSC_SER_CRC: m = DHSC_M_CRC;
                    DHSC_SER_REG: m = DHSC_M_REG;
                    default:      m = DHSC_M_NONE;
                endcase
                next_lk.mode = m;
            end
            next_lk.cnt = lk.cnt + 9'h001;
            hdr = {lk.snap[15:8], lk.snap[7:2], lk.ok2, 1'b0};
            pos = lk.cnt - DHSC_SER_HDR;
            if (lk.cnt < DHSC_SER_HDR) begin
                bit_v = hdr[lk.cnt[3:0]];
            end else if (lk.cnt < DHSC_SER_BITS) begin
                bit_v = pkt_mem[pos[8:4]][4'hF - pos[3:0]];
            end
            unique case (m)
                DHSC_M_CTL: begin
                    next_lk.sh = {serial_data_in, lk.sh[15:1]};
                    // Word posted on every sixteenth bit
                    if (lk.cnt == DHSC_CTL_BITS) begin
                        next_lk.post_word = next_lk.sh;
                        next_lk.post_crc  = 1'b0;
                        next_lk.post_tgl  = ~lk.post_tgl;
                        next_lk.cnt       = 9'h000;
                    end
                end
                DHSC_M_CRC: begin
                    next_lk.sh = {serial_data_in, lk.sh[15:1]};
                    // Every eighth bit a byte goes to the divider
                    if (lk.cnt[2:0] == DHSC_BYTE_LAST) begin
                        next_lk.post_word = next_lk.sh;
                        next_lk.post_crc  = 1'b1;
                        next_lk.post_tgl  = ~lk.post_tgl;
                        next_lk.cnt       = 9'h000;
                    end
                end
                DHSC_M_PKT: begin
                    if (lk.cnt < DHSC_SER_BITS) begin
                        next_lk.do_out = bit_v;
                        next_lk.do_oe  = !bit_v;
                    end else begin
                        next_lk.do_out = 1'b1;
                        next_lk.do_oe  = 1'b0;
                        next_lk.cnt    = lk.cnt;
                    end
                end
                DHSC_M_REG: begin
                    if (lk.cnt < DHSC_SER_HDR) begin
                        next_lk.do_out = bit_v;
                        next_lk.do_oe  = !bit_v;
                    end else begin
                        next_lk.do_out = 1'b1;
                        next_lk.do_oe  = 1'b0;
                        next_lk.cnt    = lk.cnt;
                    end
                end
                default: begin
                    next_lk.cnt = lk.cnt;
                end
            endcase
        end
    end

    // Link register; clock may stop, so reset acts alone
    always_ff @(posedge serial_shift_clock or posedge srst) begin
        if (srst) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops
    assign bus_data_out    = st.dout;
    assign bus_data_oe     = st.doe;
    assign packet_irq      = st.irq;
    assign xfer_request    = st.have;
    assign group_check_ok  = st.crc_ok;
    assign ctl_wr_stb      = st.ctl_stb;
    assign ctl_wr_addr     = st.ctl_addr;
    assign ctl_wr_data     = st.ctl_data;
    assign serial_data_out = lk.do_out;
    assign serial_data_oe  = lk.do_oe;

    ////////////////////////////////////////////////////////////////
    // Checks
    logic ok_pkt;
    assign ok_pkt = core_done && !(core_info.second_pass && core_info.parity);

    chk_irq_follows: assert property (
        @(posedge clk_sys) disable iff (srst)
        ok_pkt |=> st.upd ##1 packet_irq)
        else $error("interrupt not two cycles after packet");
    chk_parity_drop: assert property (
        @(posedge clk_sys) disable iff (srst)
        core_done && core_info.second_pass && core_info.parity && !st.upd
        |=> ##1 !packet_irq)
        else $error("second pass parity packet raised interrupt");
    chk_status_top: assert property (
        @(posedge clk_sys) disable iff (srst)
        ok_pkt |=> st.status[7] == $past(core_info.second_pass))
        else $error("status top bit wrong");
    chk_lock_bits: assert property (
        @(posedge clk_sys) disable iff (srst)
        ok_pkt |=> st.status[6:5] == $past({core_info.block_locked, core_info.frame_locked}))
        else $error("lock bits wrong");
    chk_err_pri_head: assert property (
        @(posedge clk_sys) disable iff (srst)
        ok_pkt |=> st.status[4:2] == $past({core_info.err, core_info.parity, core_info.head}))
        else $error("error, parity or head bit wrong");
    chk_index_value: assert property (
        @(posedge clk_sys) disable iff (srst)
        !st.halt && (st.s2_sel == DHSC_SEL_INDEX) && st.s2_ctl == 3'b110 && !st.rd_q
        |=> bus_data_out == {8'h00, $past(st.index)})
        else $error("index read wrong");
    chk_check_clear: assert property (
        @(posedge clk_sys) disable iff (srst)
        st.clr [*2] |-> st.crc == DHSC_CRC_CLEAR && group_check_ok)
        else $error("clear level did not hold register at zero");
    chk_ok_tracks: assert property (
        @(posedge clk_sys) disable iff (srst)
        $rose(group_check_ok) |-> st.crc == DHSC_CRC_CLEAR)
        else $error("check ok high with nonzero register");
    chk_packet_len: assert property (
        @(posedge clk_sys) disable iff (srst)
        st.have |-> st.ptr < DHSC_PKT_BYTES)
        else $error("packet pointer past 22 bytes");
    chk_reset_clear: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        $fell(srst) |-> !group_check_ok && st.crc == DHSC_CRC_CLEAR && st.status == 8'h00 && st.index == 8'h00)
        else $error("reset left state behind");
    chk_serial_latch: assert property (
        @(posedge serial_shift_clock) disable iff (srst)
        serial_chip_enable && !lk.ce_q && lk.addr == DHSC_SER_REG |=> lk.mode == DHSC_M_REG)
        else $error("register function not latched");

    cov_packet: cover property (@(posedge clk_sys) disable iff (srst) ok_pkt ##2 packet_irq);
    cov_check_ok: cover property (@(posedge clk_sys) disable iff (srst) !st.clr ##1 $rose(group_check_ok));
    cov_ser_ctl: cover property (@(posedge clk_sys) disable iff (srst) st.ctl_stb && $past(st.pt2 != st.pt3));
    cov_pkt_done: cover property (@(posedge clk_sys) disable iff (srst) $fell(st.have) && !ok_pkt);

endmodule

// ===== verification/dhsc_host.sv
// Purpose: Serial host model for the link side
// Assumes: Shift clock runs only within a transfer
// Notes:   Address then payload, each LSB first
`timescale 1ns/1ns
module dhsc_host (
    output logic scl,
    output logic ce,
    output logic sdi,
    input  wire logic sdo
);
    logic [23:0] rx; // Return line as seen before each falling edge
    initial {scl, ce, sdi} = 3'b000;
    // Eight address bits with enable low, then 16 payload bits
    task automatic xfer(input logic [23:0] v);
        for (int i = 0; i < 24; i++) begin
            ce = i > 7;
            sdi = v[i];
            #62 scl = 1'b1;
            #63 rx[i] = sdo;
            scl = 1'b0;
        end
        // Released line shows the inverse, never the last bit
        {ce, sdi} = {1'b0, ~sdi};
    endtask
endmodule

// ===== verification/testbench.sv
// Purpose: Self-checking bench for status, index and group check
// Assumes: Strobes held five clocks; host model on the link
// Notes:   Expected values are worked out here
`timescale 1ns/1ns
module testbench;
    import dhsc_pkg::*;
    logic        clk_sys = 1'b0, srst = 1'b1, core_done = 1'b0, core_load_en = 1'b0, word_mode = 1'b1, packet_irq;
    logic        chip_select_n = 1'b1, read_n = 1'b1, write_n = 1'b1, group_check_ok, xfer_request, ctl_wr_stb;
    logic        serial_data_out, serial_data_oe, bus_data_oe;
    logic [3:0]  reg_select_lines = 4'h0, ctl_wr_addr;
    logic [7:0]  ctl_wr_data;
    logic [4:0]  core_load_addr = 5'h00;
    logic [15:0] bus_data_in = 16'h0000, core_load_word = 16'h0000, bus_data_out, q, crc = 16'h0000, pw [11];
    wire         serial_shift_clock, serial_chip_enable, serial_data_in;
    dhsc_info_t  core_info = '0, info, acc = '0;
    int          err_count = 0, n_compared = 0, seed = 32'hf09c;
    dhsc_top dut (.clk_sys, .srst, .serial_shift_clock, .serial_chip_enable, .serial_data_in, .serial_data_out,
        .serial_data_oe, .reg_select_lines, .chip_select_n, .read_n, .write_n, .word_mode, .bus_data_in,
        .bus_data_out, .bus_data_oe, .core_info, .core_done, .core_load_en, .core_load_addr, .core_load_word,
        .packet_irq, .xfer_request, .group_check_ok, .ctl_wr_stb, .ctl_wr_addr, .ctl_wr_data);
    dhsc_host host (.scl(serial_shift_clock), .ce(serial_chip_enable), .sdi(serial_data_in), .sdo(~serial_data_oe));
    always #25 clk_sys = ~clk_sys;
    task automatic cmp(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) err_count++;
        if (got !== exp) $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    endtask
    // Strobes held low and high long enough for the synchroniser
    task automatic bus(input logic wr, input logic [3:0] sel, input logic [7:0] d);
        repeat (4) @(posedge clk_sys);
        {reg_select_lines, bus_data_in, chip_select_n, read_n, write_n} <= {sel, 8'h00, d, 1'b0, wr, !wr};
        repeat (5) @(posedge clk_sys);
        q = bus_data_out;
        {chip_select_n, read_n, write_n} <= 3'b111;
    endtask
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? DHSC_CRC_POLY : 16'h0000);
        return c;
    endfunction
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #1000000 err_count++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        bus(1'b1, DHSC_SEL_CTL1, 8'h80);
        bus(1'b1, DHSC_SEL_CTL1, 8'h00);
        for (int k = 0; k < 11; k++) begin
            pw[k] = 16'($random(seed));
            bus(1'b1, DHSC_SEL_CHECK, pw[k][7:0]);
            crc = crc_byte(crc, pw[k][7:0]);
            {core_load_en, core_load_addr, core_load_word} <= {1'b1, 5'(k), pw[k]};
        end
        bus(1'b1, DHSC_SEL_CHECK, crc[15:8]);
        bus(1'b1, DHSC_SEL_CHECK, crc[7:0]);
        cmp(group_check_ok, 1'b1);
        for (int k = 0; k < 12; k++) begin
            info = dhsc_info_t'(14'($random(seed)) | (k == 3 ? 14'h2200 : 14'h0000));
            {core_info, core_done, core_load_en} <= {info, 2'b10};
            @(posedge clk_sys);
            core_done <= 1'b0;
            if (!(info.second_pass && info.parity)) acc = info;
            bus(1'b0, DHSC_SEL_STATUS, 8'h00);
            cmp(q, {8'h00, acc[13:8], 2'b10});
            bus(1'b0, DHSC_SEL_INDEX, 8'h00);
            cmp(q, {8'h00, acc.block_num});
        end
        for (int k = 0; k < 12; k++) begin
            bus(1'b0, DHSC_SEL_PKT, 8'h00);
            cmp(q, k < 11 ? pw[k] : 16'h0000);
        end
        cmp(xfer_request, 1'b0);
        $display("parallel tests done");
        crc = crc_byte(crc_byte(16'h0000, pw[0][7:0]), pw[0][15:8]);
        host.xfer({pw[0], DHSC_SER_CRC});
        host.xfer({crc[7:0], crc[15:8], DHSC_SER_CRC});
        repeat (10) @(posedge clk_sys);
        cmp(group_check_ok, 1'b1);
        $display("serial check done");
        // Packet output then register output, both cut after the header
        for (int m = 0; m < 2; m++) begin
            host.xfer({16'h0000, m ? DHSC_SER_REG : DHSC_SER_PKT});
            cmp(host.rx[23:8], {acc.block_num, acc[13:8], 2'b10});
        end
        host.xfer({4'hF, DHSC_SEL_CTL1, 8'h04, DHSC_SER_CTL});
        repeat (10) @(posedge clk_sys);
        cmp({ctl_wr_addr, ctl_wr_data}, {DHSC_SEL_CTL1, 8'h04});
        bus(1'b0, DHSC_SEL_INDEX, 8'h00);
        cmp(q, 16'h0000);
        // Reset in mid run with the check flag and halt set
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        cmp({group_check_ok, xfer_request, packet_irq}, 3'b000);
        bus(1'b0, DHSC_SEL_STATUS, 8'h00);
        cmp(q, 16'h0002);
        $display("reset test done");
        stop_test;
    end
endmodule
